// ===== hw/tspp_params.svh
// constants for the timed serdes pin port
`ifndef TSPP_PARAMS_SVH
`define TSPP_PARAMS_SVH
`define TSPP_CLK_MHZ 100
`define TSPP_REF_MHZ 100
`define TSPP_CNT_W 16
`define TSPP_NUM_CB 6
`define TSPP_CB_W 3
`define TSPP_CB_REF 3'h0
`define TSPP_DIV_W 8
`define TSPP_PORT_W 4
`define TSPP_XFER_W 32
`define TSPP_FIFO_DEPTH 16
`endif

// ===== hw/tspp_pkg.sv
// types shared by the timed serdes pin port
`default_nettype none
`include "tspp_params.svh"
package tspp_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} tspp_tx_state_t;
  typedef enum logic [0:0] {RX_ARM, RX_SHIFT} tspp_rx_state_t;
  typedef struct packed {
    logic timed;
    logic [`TSPP_CNT_W-1:0] when;
    logic [`TSPP_XFER_W-1:0] data;
  } tspp_tx_word_t;
  typedef struct packed {
    logic [`TSPP_CNT_W-1:0] stamp;
    logic [`TSPP_XFER_W-1:0] data;
  } tspp_rx_word_t;
endpackage : tspp_pkg
`default_nettype wire

// ===== hw/tspp_port.sv
// timed serdes pin port: clock blocks, counter, serdes, pin muxing
`timescale 1ns/1ns
`default_nettype none
`include "tspp_params.svh"

// ==========================================================
// fifo between the core and the serializer
module tspp_fifo
  import tspp_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = `TSPP_FIFO_DEPTH
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic full_r, full_nxt, empty_r, empty_nxt;
  logic push, pop;

  assign push = in_valid_i && !full_r;
  assign pop = out_ready_i && !empty_r;
  assign in_ready_o = !full_r;
  assign out_valid_o = !empty_r;
  assign out_data_o = mem_r[rd_r];

  always_comb
  begin
    wr_nxt = push ? wr_r + AW'(1) : wr_r;
    rd_nxt = pop ? rd_r + AW'(1) : rd_r;
    cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    full_nxt = cnt_nxt == CW'(DEPTH);
    empty_nxt = cnt_nxt == '0;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      full_r <= 1'b0;
      empty_r <= 1'b1;
    end
    else
    begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
      full_r <= full_nxt;
      empty_r <= empty_nxt;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (push)
      mem_r[wr_r] <= in_data_i;
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_fifo_full_count: assert property (full_r |-> cnt_r == CW'(DEPTH))
    else $error("fifo full flag disagrees with count");
endmodule : tspp_fifo

// ==========================================================
// one port with its clock blocks
module tspp_port
  import tspp_pkg::*;
#(
  parameter int PORT_W = `TSPP_PORT_W,
  parameter int XFER_W = `TSPP_XFER_W,
  parameter int DEPTH = `TSPP_FIFO_DEPTH
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // port configuration
  input wire logic port_en_i,
  input wire logic dir_out_i,
  input wire logic open_coll_i,
  input wire logic link_en_i,
  input wire logic [PORT_W-1:0] narrow_claim_i,
  input wire logic strobe_en_i,
  input wire logic cond_en_i,
  input wire logic [PORT_W-1:0] cond_val_i,
  // clock block configuration
  input wire logic clk_sel_wr_i,
  input wire logic [`TSPP_CB_W-1:0] clk_sel_i,
  input wire logic [`TSPP_NUM_CB-1:0] cb_ext_i,
  input wire logic [`TSPP_NUM_CB*`TSPP_DIV_W-1:0] cb_div_i,
  // core output side
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire tspp_tx_word_t tx_word_i,
  output logic tx_busy_o,
  output logic [`TSPP_CNT_W-1:0] tx_stamp_o,
  // core input side
  output logic rx_valid_o,
  input wire logic rx_take_i,
  output tspp_rx_word_t rx_word_o,
  output logic event_o,
  output logic [`TSPP_CNT_W-1:0] count_o,
  // pins
  input wire logic [PORT_W-1:0] pad_i,
  output logic [PORT_W-1:0] pad_o,
  output logic [PORT_W-1:0] pad_oe_o,
  input wire logic ext_clk_i,
  input wire logic ready_in_i,
  output logic output_ready_strobe_o
);
  localparam int BEATS = XFER_W / PORT_W;
  localparam int BW = $clog2(BEATS+1);
  localparam int REF_DIV = `TSPP_CLK_MHZ / `TSPP_REF_MHZ;
  localparam int RW = $clog2(REF_DIV+1);
  localparam int NCB = `TSPP_NUM_CB;
  localparam int DW = `TSPP_DIV_W;

  // value moves only once second and third stage agree
  function automatic logic [PORT_W+1:0] settle(input logic [PORT_W+1:0] s2,
    input logic [PORT_W+1:0] s3, input logic [PORT_W+1:0] old);
    settle = (s2 & s3) | (old & (s2 | s3));
  endfunction : settle

  // ==========================================================
  // pin synchronisers
  logic [PORT_W+1:0] s1_r, s2_r, s3_r, st_r, st_nxt;
  logic [PORT_W-1:0] pins_in;
  logic ext_clk_s, ready_in_s, ext_prev_r;

  always_comb
  begin
    st_nxt = settle(s2_r, s3_r, st_r);
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      st_r <= '0;
      ext_prev_r <= 1'b0;
    end
    else
    begin
      s1_r <= {ready_in_i, ext_clk_i, pad_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
      st_r <= st_nxt;
      ext_prev_r <= ext_clk_s;
    end
  end

  assign pins_in = st_r[PORT_W-1:0];
  assign ext_clk_s = st_r[PORT_W];
  assign ready_in_s = st_r[PORT_W+1];

  // ==========================================================
  // clock blocks
  logic [RW-1:0] ref_cnt_r, ref_cnt_nxt;
  logic ref_tick, ext_tick;
  logic [DW-1:0] div_r [NCB];
  logic [DW-1:0] div_nxt [NCB];
  logic [NCB-1:0] cb_tick;
  logic [`TSPP_CB_W-1:0] sel_r, sel_nxt;
  logic tick;

  assign ref_tick = ref_cnt_r == RW'(REF_DIV-1);
  assign ext_tick = ext_clk_s && !ext_prev_r;

  always_comb
  begin
    logic src;
    src = 1'b0;
    ref_cnt_nxt = ref_tick ? '0 : ref_cnt_r + RW'(1);
    cb_tick[0] = ref_tick;
    div_nxt[0] = '0;
    for (int k = 1; k < NCB; k++)
    begin
      src = cb_ext_i[k] ? ext_tick : ref_tick;
      cb_tick[k] = src && div_r[k] == cb_div_i[k*DW +: DW];
      div_nxt[k] = !src ? div_r[k] : cb_tick[k] ? '0 : div_r[k] + DW'(1);
    end
    // codes past the last block would select no tick at all, so they are ignored
    sel_nxt = (clk_sel_wr_i && clk_sel_i < `TSPP_CB_W'(NCB)) ? clk_sel_i : sel_r;
  end

  assign tick = cb_tick[sel_r];

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      ref_cnt_r <= '0;
      sel_r <= `TSPP_CB_REF;
      for (int k = 0; k < NCB; k++)
        div_r[k] <= '0;
    end
    else
    begin
      ref_cnt_r <= ref_cnt_nxt;
      sel_r <= sel_nxt;
      div_r <= div_nxt;
    end
  end

  // ==========================================================
  // port counter
  logic [`TSPP_CNT_W-1:0] cnt_r, cnt_nxt;

  always_comb
  begin
    cnt_nxt = tick ? cnt_r + `TSPP_CNT_W'(1) : cnt_r;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  assign count_o = cnt_r;

  // ==========================================================
  // output path: fifo, serializer, pin drive
  tspp_tx_word_t fifo_word;
  logic fifo_valid, fifo_pop, fifo_ready;
  tspp_tx_state_t tx_r, tx_nxt;
  logic [XFER_W-1:0] tsh_r, tsh_nxt;
  logic [`TSPP_CNT_W-1:0] when_r, when_nxt, tstamp_r, tstamp_nxt;
  logic [BW-1:0] tbeat_r, tbeat_nxt;
  logic [PORT_W-1:0] dval_r, dval_nxt, oe_r, oe_nxt, own;
  logic ostrobe_r, ostrobe_nxt, tready_r, busy_r;
  logic out_mode;

  tspp_fifo #(.WIDTH($bits(tspp_tx_word_t)), .DEPTH(DEPTH)) tspp_fifo_inst (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(fifo_ready),
    .in_data_i(tx_word_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_word)
  );

  assign out_mode = port_en_i && dir_out_i;
  // link wins over everything, narrower ports over this one
  assign own = ~narrow_claim_i & {PORT_W{port_en_i && !link_en_i}};
  // serializer stalls the fifo, so a full fifo pushes back on the core
  assign fifo_pop = tx_r == TX_IDLE && out_mode;

  always_comb
  begin
    tx_nxt = tx_r;
    tsh_nxt = tsh_r;
    when_nxt = when_r;
    tstamp_nxt = tstamp_r;
    tbeat_nxt = tbeat_r;
    dval_nxt = dval_r;
    ostrobe_nxt = tick ? 1'b0 : ostrobe_r;
    case (tx_r)
      TX_IDLE:
      begin
        if (fifo_pop && fifo_valid)
        begin
          tsh_nxt = fifo_word.data;
          when_nxt = fifo_word.when;
          tbeat_nxt = '0;
          tx_nxt = fifo_word.timed ? TX_WAIT : TX_SHIFT;
        end
      end
      TX_WAIT:
      begin
        if (tick && cnt_r == when_r)
          tx_nxt = TX_SHIFT;
      end
      TX_SHIFT:
      begin
        if (tick)
        begin
          dval_nxt = tsh_r[PORT_W-1:0];
          tsh_nxt = tsh_r >> PORT_W;
          ostrobe_nxt = strobe_en_i;
          tbeat_nxt = tbeat_r + BW'(1);
          if (tbeat_r == '0)
            tstamp_nxt = cnt_r;
          // always a full word, even with pins overridden
          if (tbeat_r == BW'(BEATS-1))
            tx_nxt = TX_IDLE;
        end
      end
      default: tx_nxt = TX_IDLE;
    endcase
    // open collector only drives the zeros
    oe_nxt = own & {PORT_W{out_mode}} & (open_coll_i ? ~dval_nxt : '1);
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      tx_r <= TX_IDLE;
      tsh_r <= '0;
      when_r <= '0;
      tstamp_r <= '0;
      tbeat_r <= '0;
      dval_r <= '0;
      oe_r <= '0;
      ostrobe_r <= 1'b0;
      tready_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      tx_r <= tx_nxt;
      tsh_r <= tsh_nxt;
      when_r <= when_nxt;
      tstamp_r <= tstamp_nxt;
      tbeat_r <= tbeat_nxt;
      dval_r <= dval_nxt;
      oe_r <= oe_nxt;
      ostrobe_r <= ostrobe_nxt;
      tready_r <= fifo_ready;
      busy_r <= tx_nxt != TX_IDLE || fifo_valid;
    end
  end

  // open collector pads only ever pull low
  assign pad_o = open_coll_i ? '0 : dval_r;
  assign pad_oe_o = oe_r;
  assign output_ready_strobe_o = ostrobe_r;
  assign tx_ready_o = tready_r;
  assign tx_busy_o = busy_r;
  assign tx_stamp_o = tstamp_r;

  // ==========================================================
  // input path: conditional start, deserializer, transfer register
  tspp_rx_state_t rx_r, rx_nxt;
  logic [XFER_W-1:0] rsh_r, rsh_nxt;
  logic [BW-1:0] rbeat_r, rbeat_nxt;
  tspp_rx_word_t rword_r, rword_nxt;
  logic rvalid_r, rvalid_nxt, event_r, event_nxt, in_mode, take;

  assign in_mode = port_en_i && !dir_out_i && !link_en_i;
  // with strobes enabled, a beat is taken only when the outside has it ready; otherwise on every tick
  assign take = tick && (!strobe_en_i || ready_in_s);

  always_comb
  begin
    rx_nxt = rx_r;
    rsh_nxt = rsh_r;
    rbeat_nxt = rbeat_r;
    rword_nxt = rword_r;
    event_nxt = 1'b0;
    // a fresh word wins over a take in the same cycle
    rvalid_nxt = rvalid_r && !rx_take_i;
    case (rx_r)
      RX_ARM:
      begin
        rbeat_nxt = '0;
        if (in_mode && tick && (!cond_en_i || pins_in == cond_val_i))
          rx_nxt = RX_SHIFT;
      end
      RX_SHIFT:
      begin
        if (!in_mode)
          rx_nxt = RX_ARM;
        else if (take)
        begin
          rsh_nxt = {pins_in, rsh_r[XFER_W-1:PORT_W]};
          rbeat_nxt = rbeat_r + BW'(1);
          if (rbeat_r == BW'(BEATS-1))
          begin
            rword_nxt.data = rsh_nxt;
            rword_nxt.stamp = cnt_r;
            rvalid_nxt = 1'b1;
            event_nxt = 1'b1;
            rbeat_nxt = '0;
            rx_nxt = cond_en_i ? RX_ARM : RX_SHIFT;
          end
        end
      end
      default: rx_nxt = RX_ARM;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rx_r <= RX_ARM;
      rsh_r <= '0;
      rbeat_r <= '0;
      rword_r <= '0;
      rvalid_r <= 1'b0;
      event_r <= 1'b0;
    end
    else
    begin
      rx_r <= rx_nxt;
      rsh_r <= rsh_nxt;
      rbeat_r <= rbeat_nxt;
      rword_r <= rword_nxt;
      rvalid_r <= rvalid_nxt;
      event_r <= event_nxt;
    end
  end

  assign rx_word_o = rword_r;
  assign rx_valid_o = rvalid_r;
  assign event_o = event_r;

  // ==========================================================
  // checks
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_timed_due;
    tx_r == TX_WAIT && tick && cnt_r == when_r;
  endsequence
  sequence s_first_beat;
    tx_r == TX_SHIFT && tbeat_r == '0;
  endsequence

  a_cnt_tick_step: assert property (tick |=> cnt_r == $past(cnt_r) + `TSPP_CNT_W'(1))
    else $error("counter missed a tick");
  a_cnt_hold_idle: assert property (!tick |=> $stable(cnt_r))
    else $error("counter moved without a tick");
  a_timed_start: assert property (s_timed_due |=> s_first_beat)
    else $error("timed output did not start at its count");
  a_oc_no_high: assert property (open_coll_i && $past(open_coll_i) |->
    (pad_oe_o & dval_r) == '0)
    else $error("open collector drove a one");
  a_link_release: assert property (link_en_i |=> pad_oe_o == '0)
    else $error("port drove pins under an enabled link");
  a_narrow_wins: assert property (1'b1 |=> (pad_oe_o & $past(narrow_claim_i)) == '0)
    else $error("claimed pin still driven");
  a_reset_block0: assert property ($rose(!rst_i) |-> sel_r == `TSPP_CB_REF)
    else $error("port not on clock block zero after reset");
  a_event_data: assert property (event_o |->
    rx_valid_o && rx_word_o.stamp == $past(cnt_r))
    else $error("event without stamped data");
  a_event_pulse: assert property (event_o |=> !event_o || $past(take))
    else $error("event held without a new word");
  a_strobe_tick: assert property ($rose(output_ready_strobe_o) |-> $past(tick))
    else $error("strobe rose off a tick");
endmodule : tspp_port

`default_nettype wire

// ===== tb/tspp_pins_model.sv
// application hardware model sitting on the port pins
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// pins, pull-ups, strobes and an external clock
module tspp_pins_model
  import tspp_pkg::*;
(
  // clock
  input wire logic clock_i,
  // device side of the pins
  input wire logic [3:0] dev_pad_i,
  input wire logic [3:0] dev_oe_i,
  input wire logic dev_strobe_i,
  // wire levels seen by the device
  output logic [3:0] line_o,
  output logic ext_clk_o,
  output logic ready_o
);
  logic [3:0] drv_en = 4'h0;
  logic [3:0] drv_val = 4'h0;
  logic ext_lvl = 1'b0;
  logic rdy_lvl = 1'b0;
  logic [7:0] beats[$];

  // board pull-ups lift every pin that nobody drives
  assign line_o = (dev_oe_i & dev_pad_i) | (~dev_oe_i & drv_en & drv_val) | (~dev_oe_i & ~drv_en);
  assign ext_clk_o = ext_lvl;
  assign ready_o = rdy_lvl;

  // keep oe beside the wire level of each strobed beat
  always @(posedge clock_i)
    if (dev_strobe_i === 1'b1)
      beats.push_back({dev_oe_i, line_o});

  // one word, low nibble first; ready is a level, four cycles wide, so a
  // divide-by-four block sees exactly one tick inside it
  task automatic send_word(input logic [31:0] w);
    drv_en = 4'hf;
    for (int b = 0; b < 8; b++)
    begin
      drv_val = w[b*4 +: 4];
      repeat (2) @(negedge clock_i);
      rdy_lvl = 1'b1;
      repeat (4) @(negedge clock_i);
      rdy_lvl = 1'b0;
      repeat (2) @(negedge clock_i);
    end
    drv_en = 4'h0;
  endtask : send_word

  // steady level with no ready, e.g. a start pattern before a word
  task automatic hold_lines(input logic [3:0] v, input int n);
    drv_en = 4'hf;
    drv_val = v;
    repeat (n) @(negedge clock_i);
  endtask : hold_lines

  // clock only runs while asked; even delays never meet an odd clock edge,
  // and each level spans at least two samples so the filter keeps it
  task automatic ext_edges(input int n);
    repeat (n)
    begin
      #24 ext_lvl = 1'b1;
      #24 ext_lvl = 1'b0;
    end
  endtask : ext_edges
endmodule : tspp_pins_model
`default_nettype wire

// ===== tb/tspp_port_bench.sv
// self-checking bench for the timed serdes pin port
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// stimulus and checks
module tspp_port_bench
  import tspp_pkg::*;
;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic port_en_i = 1'b0, dir_out_i = 1'b0, open_coll_i = 1'b0, link_en_i = 1'b0;
  logic strobe_en_i = 1'b0, cond_en_i = 1'b0, clk_sel_wr_i = 1'b0, tx_valid_i = 1'b0;
  logic rx_take_i = 1'b0;
  logic [3:0] narrow_claim_i = 4'h0, cond_val_i = 4'h0;
  logic [2:0] clk_sel_i = 3'h0;
  logic [5:0] cb_ext_i = 6'h02;
  logic [47:0] cb_div_i = 48'h0000_0003_0100;
  tspp_tx_word_t tx_word_i = '0;
  logic tx_ready_o, tx_busy_o, rx_valid_o, event_o, output_ready_strobe_o;
  logic [15:0] tx_stamp_o, count_o;
  tspp_rx_word_t rx_word_o;
  logic [3:0] pad_o, pad_oe_o;
  wire logic [3:0] pad_i;
  wire logic ext_clk_i, ready_in_i;
  int mismatches = 0, num_checks = 0, cycles = 0;

  always #5 clock_i = ~clock_i;

  tspp_port #(.PORT_W(4), .XFER_W(32), .DEPTH(16)) tspp_port_inst (
    .clock_i(clock_i), .rst_i(rst_i), .port_en_i(port_en_i), .dir_out_i(dir_out_i),
    .open_coll_i(open_coll_i), .link_en_i(link_en_i), .narrow_claim_i(narrow_claim_i),
    .strobe_en_i(strobe_en_i), .cond_en_i(cond_en_i), .cond_val_i(cond_val_i),
    .clk_sel_wr_i(clk_sel_wr_i), .clk_sel_i(clk_sel_i), .cb_ext_i(cb_ext_i),
    .cb_div_i(cb_div_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .tx_word_i(tx_word_i), .tx_busy_o(tx_busy_o), .tx_stamp_o(tx_stamp_o),
    .rx_valid_o(rx_valid_o), .rx_take_i(rx_take_i), .rx_word_o(rx_word_o),
    .event_o(event_o), .count_o(count_o), .pad_i(pad_i), .pad_o(pad_o),
    .pad_oe_o(pad_oe_o), .ext_clk_i(ext_clk_i), .ready_in_i(ready_in_i),
    .output_ready_strobe_o(output_ready_strobe_o));

  tspp_pins_model tspp_pins_model_inst (
    .clock_i(clock_i), .dev_pad_i(pad_o), .dev_oe_i(pad_oe_o),
    .dev_strobe_i(output_ready_strobe_o), .line_o(pad_i), .ext_clk_o(ext_clk_i),
    .ready_o(ready_in_i));

  // cycle ceiling
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      $display("wrong value at %0t: run hung", $time);
      wrap_up();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : cyc

  task automatic tx_send(input logic timed, input logic [15:0] when, input logic [31:0] d);
    int n;
    n = 0;
    while (tx_ready_o !== 1'b1 && n < 100)
    begin
      cyc(1);
      n++;
    end
    tx_valid_i = 1'b1;
    tx_word_i = '{timed, when, d};
    cyc(1);
    tx_valid_i = 1'b0;
  endtask : tx_send

  // busy is registered, so give it time to rise before polling
  task automatic wait_idle();
    int n;
    n = 0;
    cyc(3);
    while (tx_busy_o !== 1'b0 && n < 1000)
    begin
      cyc(1);
      n++;
    end
    cyc(3);
  endtask : wait_idle

  task automatic sel(input logic [2:0] k);
    clk_sel_i = k;
    clk_sel_wr_i = 1'b1;
    cyc(1);
    clk_sel_wr_i = 1'b0;
  endtask : sel

  // claims lag by a cycle, hence the settle time
  task automatic out_word(input logic oc, input logic [3:0] claim, input logic [31:0] d);
    logic [3:0] nib;
    logic [3:0] oe_exp;
    open_coll_i = oc;
    narrow_claim_i = claim;
    cyc(2);
    tspp_pins_model_inst.beats.delete();
    tx_send(1'b0, 16'h0, d);
    wait_idle();
    check(tspp_pins_model_inst.beats.size(), 8, "beat count");
    for (int b = 0; b < 8; b++)
    begin
      nib = d[b*4 +: 4];
      oe_exp = (oc ? ~nib : 4'hf) & ~claim;
      check(tspp_pins_model_inst.beats[b], {oe_exp, nib | claim}, "beat");
    end
    open_coll_i = 1'b0;
    narrow_claim_i = 4'h0;
  endtask : out_word

  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [15:0] c0;
    check(count_o, 16'h0, "count after reset");
    check(pad_oe_o, 4'h0, "oe after reset");
    check(tx_ready_o, 1'b0, "ready in first cycle");
    cyc(1);
    check(tx_ready_o, 1'b1, "ready after reset");
    c0 = count_o;
    cyc(10);
    check(count_o, c0 + 16'ha, "count per cycle");
  endtask : t_reset

  task automatic t_out();
    out_word(1'b0, 4'h0, 32'h8c3a_5e71);
    out_word(1'b1, 4'h0, 32'h0f5a_96c3);
    out_word(1'b0, 4'h3, 32'h7e21_d4b8);
  endtask : t_out

  task automatic t_timed();
    logic [15:0] w;
    w = count_o + 16'h0028;
    tx_send(1'b1, w, 32'ha5a5_3c3c);
    wait_idle();
    check(tx_stamp_o, w + 16'h1, "timed stamp");
  endtask : t_timed

  task automatic t_link();
    link_en_i = 1'b1;
    cyc(2);
    tx_send(1'b0, 16'h0, 32'h0000_0000);
    repeat (12)
    begin
      cyc(1);
      check(pad_oe_o, 4'h0, "oe under link");
    end
    wait_idle();
    link_en_i = 1'b0;
  endtask : t_link

  task automatic t_input();
    int n;
    n = 0;
    dir_out_i = 1'b0;
    // ready is a level, so sample on a divide-by-four block
    sel(3'h2);
    cyc(4);
    fork
      tspp_pins_model_inst.send_word(32'h1234_abcd);
    join_none
    while (event_o !== 1'b1 && n < 400)
    begin
      cyc(1);
      n++;
    end
    check(rx_word_o.data, 32'h1234_abcd, "rx data");
    check(rx_valid_o, 1'b1, "rx valid");
    check(pad_oe_o, 4'h0, "input oe");
    check(rx_word_o.stamp, 16'(count_o - 16'h1), "rx stamp");
    cyc(1);
    check(event_o, 1'b0, "event pulse");
    rx_take_i = 1'b1;
    cyc(1);
    rx_take_i = 1'b0;
    cyc(1);
    check(rx_valid_o, 1'b0, "rx taken");
    wait fork;
    // re-armed with a condition: a word before the match is ignored
    cond_en_i = 1'b1;
    cond_val_i = 4'h9;
    link_en_i = 1'b1;
    cyc(2);
    link_en_i = 1'b0;
    tspp_pins_model_inst.send_word(32'h8765_4321);
    cyc(8);
    check(rx_valid_o, 1'b0, "word before match");
    fork
    begin
      tspp_pins_model_inst.hold_lines(4'h9, 8);
      tspp_pins_model_inst.send_word(32'h2468_ace0);
    end
    join_none
    n = 0;
    while (event_o !== 1'b1 && n < 400)
    begin
      cyc(1);
      n++;
    end
    check(rx_word_o.data, 32'h2468_ace0, "word after match");
    wait fork;
    cond_en_i = 1'b0;
  endtask : t_input

  task automatic t_clocks();
    logic [15:0] c0;
    sel(3'h2);
    c0 = count_o;
    cyc(100);
    check((count_o - c0) inside {[16'h18 : 16'h1a]}, 1'b1, "divided rate");
    sel(3'h1);
    c0 = count_o;
    cyc(20);
    check(count_o, c0, "ext clock idle");
    tspp_pins_model_inst.ext_edges(10);
    cyc(6);
    check((count_o - c0) inside {[16'h4 : 16'h5]}, 1'b1, "ext divided");
    sel(3'h0);
  endtask : t_clocks

  task automatic t_fifo();
    int n;
    n = 0;
    dir_out_i = 1'b1;
    cyc(2);
    tspp_pins_model_inst.beats.delete();
    tx_send(1'b1, count_o + 16'h00c8, 32'h0000_0000);
    // valid was just lowered; let an edge pass before raising it again
    cyc(1);
    tx_valid_i = 1'b1;
    tx_word_i = '{1'b0, 16'h0, 32'h5555_aaaa};
    while (tx_ready_o === 1'b1 && n < 40)
    begin
      cyc(1);
      n++;
    end
    tx_valid_i = 1'b0;
    check(n < 40, 1'b1, "fifo refuses");
    wait_idle();
    check(tspp_pins_model_inst.beats.size(), 17 * 8, "drained beats");
    check(tx_busy_o, 1'b0, "fifo empty");
  endtask : t_fifo

  initial
  begin
    cyc(12);
    rst_i = 1'b0;
    t_reset();
    port_en_i = 1'b1;
    dir_out_i = 1'b1;
    strobe_en_i = 1'b1;
    cyc(2);
    t_out();
    t_timed();
    t_link();
    t_input();
    t_clocks();
    t_fifo();
    wrap_up();
  end
endmodule : tspp_port_bench
`default_nettype wire
